// >>> logic/ldup_pacing.v
`timescale 1ns/1ns
`include "ldup_defines.vh"
module ldup_pacing (
	input wire mclk,
	input wire sys_rst,
	input wire regWrite,
	input wire [6:0] regAddr,
	input wire [12:0] regWrData,
	output reg [12:0] regRdData,
	input wire [71:0] dutyTarget,
	output reg [71:0] dutyApplied,
	output reg [5:0] dutyUpdate,
	output reg periodStart
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Returns the period count minus one for an interval select.
	function [4:0] ldupLastPeriod;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: begin
					ldupLastPeriod = `LDUP_LAST_P1;
				end
				3'h1: begin
					ldupLastPeriod = `LDUP_LAST_P2;
				end
				3'h2: begin
					ldupLastPeriod = `LDUP_LAST_P4;
				end
				3'h3: begin
					ldupLastPeriod = `LDUP_LAST_P8;
				end
				3'h4: begin
					ldupLastPeriod = `LDUP_LAST_P16;
				end
				default: begin
					ldupLastPeriod = `LDUP_LAST_P32;
				end
			endcase
		end
	endfunction

	// Tells whether a channel's interval has run out at this boundary.
	// Greater-or-equal lets a shortened select take hold at the next boundary.
	function ldupExpired;
		input [4:0] cnt;
		input [2:0] sel;
		begin
			ldupExpired = (cnt >= ldupLastPeriod(sel));
		end
	endfunction

	// Tells whether an address selects a given register offset.
	function ldupAddrHit;
		input [6:0] addr;
		input [6:0] ofs;
		begin
			ldupAddrHit = (addr == ofs);
		end
	endfunction

	// Packs three selects into a register image with zero reserved bits.
	function [12:0] ldupPack;
		input [2:0] hi;
		input [2:0] mid;
		input [2:0] lo;
		begin
			ldupPack = {2'h0, hi, 1'h0, mid, 1'h0, lo};
		end
	endfunction

	// ----------------------------------------
	// State and next-state signals
	// ----------------------------------------
	reg [2:0] sel_q [0:5];
	reg [2:0] sel_d [0:5];
	reg [11:0] phase_q;
	reg [11:0] phase_d;
	reg [4:0] periodCnt_q [0:5];
	reg [4:0] periodCnt_d [0:5];
	reg [12:0] rdData_d;
	reg [71:0] duty_d;
	reg [5:0] update_d;
	reg periodStart_d;
	integer iSelD;
	integer iSelQ;
	integer iCntD;
	integer iCntQ;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------

	// Each mapped offset is decoded once and shared by write and read paths.
	wire hitLow;
	wire hitHigh;
	assign hitLow = ldupAddrHit(regAddr, `LDUP_OFS_INTERVAL_3_5);
	assign hitHigh = ldupAddrHit(regAddr, `LDUP_OFS_INTERVAL_6_8);

	// ----------------------------------------
	// Interval select registers
	// ----------------------------------------

	// A write to a mapped offset replaces all three selects of that register.
	always @* begin
		for (iSelD = 0; iSelD < 6; iSelD = iSelD + 1) begin
			sel_d[iSelD] = sel_q[iSelD];
		end
		if (regWrite && hitLow) begin
			sel_d[0] = regWrData[`LDUP_FLD_LO +: 3];
			sel_d[1] = regWrData[`LDUP_FLD_MID +: 3];
			sel_d[2] = regWrData[`LDUP_FLD_HI +: 3];
		end
		if (regWrite && hitHigh) begin
			sel_d[3] = regWrData[`LDUP_FLD_LO +: 3];
			sel_d[4] = regWrData[`LDUP_FLD_MID +: 3];
			sel_d[5] = regWrData[`LDUP_FLD_HI +: 3];
		end
	end

	// Reset returns every channel to one update per period.
	always @(posedge mclk) begin
		if (sys_rst) begin
			for (iSelQ = 0; iSelQ < 6; iSelQ = iSelQ + 1) begin
				sel_q[iSelQ] <= `LDUP_SEL_RESET;
			end
		end else begin
			for (iSelQ = 0; iSelQ < 6; iSelQ = iSelQ + 1) begin
				sel_q[iSelQ] <= sel_d[iSelQ];
			end
		end
	end

	// ----------------------------------------
	// Register read path
	// ----------------------------------------

	// Reserved bits read as zero and unmapped offsets read as all zeros.
	always @* begin
		if (hitLow) begin
			rdData_d = ldupPack(sel_q[2], sel_q[1], sel_q[0]);
		end else if (hitHigh) begin
			rdData_d = ldupPack(sel_q[5], sel_q[4], sel_q[3]);
		end else begin
			rdData_d = `LDUP_INTERVAL_RESET;
		end
	end

	// Read data is registered, so it appears one cycle after the address.
	always @(posedge mclk) begin
		if (sys_rst) begin
			regRdData <= `LDUP_INTERVAL_RESET;
		end else begin
			regRdData <= rdData_d;
		end
	end

	// ----------------------------------------
	// PWM period timing
	// ----------------------------------------

	// The last phase of each period marks the boundary where duties may change.
	wire phaseEnd;
	assign phaseEnd = (phase_q == `LDUP_PHASE_LAST);

	// The phase counter wraps by itself every 4096 clocks.
	always @* begin
		phase_d = phase_q + `LDUP_PHASE_STEP;
		periodStart_d = phaseEnd;
	end

	// The period pulse is registered so it lines up with the update pulses.
	always @(posedge mclk) begin
		if (sys_rst) begin
			phase_q <= `LDUP_PHASE_RESET;
			periodStart <= 1'b0;
		end else begin
			phase_q <= phase_d;
			periodStart <= periodStart_d;
		end
	end

	// ----------------------------------------
	// Per-channel pacing and duty latch
	// ----------------------------------------

	// Each channel counts whole periods and takes its 12-bit duty on expiry.
	// Between boundaries the applied duty holds, so no period is cut short.
	always @* begin
		duty_d = dutyApplied;
		update_d = `LDUP_UPDATE_RESET;
		for (iCntD = 0; iCntD < 6; iCntD = iCntD + 1) begin
			periodCnt_d[iCntD] = periodCnt_q[iCntD];
			if (phaseEnd) begin
				if (ldupExpired(periodCnt_q[iCntD], sel_q[iCntD])) begin
					periodCnt_d[iCntD] = `LDUP_CNT_RESET;
					duty_d[iCntD*12 +: 12] = dutyTarget[iCntD*12 +: 12];
					update_d[iCntD] = 1'b1;
				end else begin
					periodCnt_d[iCntD] = periodCnt_q[iCntD] + `LDUP_CNT_STEP;
				end
			end
		end
	end

	// Applied duties, update pulses and period counters all clear on reset.
	always @(posedge mclk) begin
		if (sys_rst) begin
			dutyApplied <= {6{`LDUP_DUTY_RESET}};
			dutyUpdate <= `LDUP_UPDATE_RESET;
			for (iCntQ = 0; iCntQ < 6; iCntQ = iCntQ + 1) begin
				periodCnt_q[iCntQ] <= `LDUP_CNT_RESET;
			end
		end else begin
			dutyApplied <= duty_d;
			dutyUpdate <= update_d;
			for (iCntQ = 0; iCntQ < 6; iCntQ = iCntQ + 1) begin
				periodCnt_q[iCntQ] <= periodCnt_d[iCntQ];
			end
		end
	end

endmodule

// >>> shared/ldup_defines.vh
`ifndef LDUP_DEFINES_VH
`define LDUP_DEFINES_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define LDUP_ADDR_W 7
`define LDUP_OFS_INTERVAL_3_5 7'h1A
`define LDUP_OFS_INTERVAL_6_8 7'h1B
`define LDUP_REG_W 13
`define LDUP_INTERVAL_RESET 13'h0000
// Field positions (low bit of each 3-bit select).
`define LDUP_FLD_LO 0
`define LDUP_FLD_MID 4
`define LDUP_FLD_HI 8
`define LDUP_SEL_RESET 3'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define LDUP_PERIOD_CLKS 4096
`define LDUP_PHASE_W 12
`define LDUP_PHASE_LAST 12'hFFF
`define LDUP_DUTY_W 12
`define LDUP_DUTY_RESET 12'h000
`define LDUP_MAX_PERIODS_LOG2 5
`define LDUP_PHASE_RESET 12'h000
`define LDUP_PHASE_STEP 12'h001
`define LDUP_CNT_RESET 5'h00
`define LDUP_CNT_STEP 5'h01
`define LDUP_UPDATE_RESET 6'h00
// Last period index for each interval select code.
`define LDUP_LAST_P1 5'h00
`define LDUP_LAST_P2 5'h01
`define LDUP_LAST_P4 5'h03
`define LDUP_LAST_P8 5'h07
`define LDUP_LAST_P16 5'h0F
`define LDUP_LAST_P32 5'h1F
`endif

// >>> verif/ldup_pacing_chk.sv
`timescale 1ns/1ns
module ldup_pacing_chk(input wire mclk, input wire sys_rst, input wire regWrite,
	input wire [6:0] regAddr, input wire [12:0] regWrData, input wire [12:0] regRdData,
	input wire [71:0] dutyTarget, input wire [71:0] dutyApplied, input wire [5:0] dutyUpdate,
	input wire periodStart);
reg [12:0] gapQ;
reg seenQ;
default clocking @(posedge mclk); endclocking
default disable iff (sys_rst);
// Clocks since the last period pulse.
always @(posedge mclk) begin
	gapQ <= (sys_rst || periodStart) ? 13'h0000 : gapQ + 13'h0001;
	seenQ <= sys_rst ? 1'b0 : (seenQ | periodStart);
end
period_len_a: assert property (seenQ && periodStart |-> gapQ == 13'h0FFF) else $error("period length");
period_miss_a: assert property (seenQ |-> gapQ <= 13'h0FFF) else $error("period missing");
upd_align_a: assert property (|dutyUpdate |-> periodStart) else $error("update off boundary");
duty_latch_a: assert property (dutyUpdate[0] |-> dutyApplied[11:0] == $past(dutyTarget[11:0])) else $error("duty latch");
duty_hold_a: assert property (!(|dutyUpdate) |-> $stable(dutyApplied)) else $error("duty moved");
rsvd_zero_a: assert property ((regRdData & 13'h1888) == 13'h0000) else $error("reserved bit set");
unmapped_rd_a: assert property (regAddr != 7'h1A && regAddr != 7'h1B |=> regRdData == 13'h0000) else $error("unmapped read");
lo_readback_a: assert property (regWrite && regAddr == 7'h1A ##1 regAddr == 7'h1A && !regWrite
	|=> regRdData == ($past(regWrData, 2) & 13'h0777)) else $error("readback low");
hi_readback_a: assert property (regWrite && regAddr == 7'h1B ##1 regAddr == 7'h1B && !regWrite
	|=> regRdData == ($past(regWrData, 2) & 13'h0777)) else $error("readback high");
endmodule
bind ldup_pacing ldup_pacing_chk ldup_pacing_chk_inst(.*);

// >>> verif/ldup_host_model.sv
`timescale 1ns/1ns
// Microcontroller stand-in that writes and reads the interval registers.
module ldup_host_model(input wire mclk, input wire [12:0] regRdData, output reg regWrite = 1'b0,
	output reg [6:0] regAddr = 7'h00, output reg [12:0] regWrData = 13'h0000);
task wr(input [6:0] a, input [12:0] d); begin
	@(posedge mclk);
	regWrite <= 1'b1;
	regAddr <= a;
	regWrData <= d;
	@(posedge mclk);
	regWrite <= 1'b0;
end endtask
task rd(input [6:0] a, output [12:0] d); begin
	@(posedge mclk);
	regAddr <= a;
	repeat (2) @(posedge mclk);
	#1 d = regRdData;
end endtask
endmodule

// >>> verif/led_duty_update_pacing_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("CHECK FAILED %0t mismatch", $time); end end
module led_duty_update_pacing_tb;
reg mclk = 1'b0;
reg sys_rst = 1'b1;
reg [71:0] dutyTarget = 72'h0;
wire regWrite, periodStart;
wire [6:0] regAddr;
wire [12:0] regWrData, regRdData;
wire [71:0] dutyApplied;
wire [5:0] dutyUpdate;
int fail_count = 0, compares = 0, cyc = 0, cnt[6] = '{0, 0, 0, 0, 0, 0}, codes[6] = '{0, 1, 2, 3, 5, 7};
bit on = 0;
reg [31:0] rng = 32'd92678;
reg [12:0] rdv;
ldup_pacing ldup_pacing_inst(.*);
ldup_host_model ldup_host_model_inst(.*);
always #5 mclk = ~mclk;
function [31:0] xs(input [31:0] x); begin x ^= x << 13; x ^= x >> 17; x ^= x << 5; xs = x; end endfunction
function int expc(input int c); expc = (c < 4) ? (8 >> c) : 0; endfunction
task stop_test; begin
	$display("compares %0d fail_count %0d", compares, fail_count);
	if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
	else $display("TESTS FAILED");
	$finish;
end endtask
// Random duty requests, update counting and the hang guard.
always @(posedge mclk) begin
	rng <= xs(rng);
	dutyTarget <= {rng, rng, rng[7:0]};
	cyc++;
	if (on) for (int i = 0; i < 6; i++) cnt[i] += dutyUpdate[i];
	if (cyc > 90000) begin fail_count++; stop_test; end
end
// Register checks, then eight periods of counted updates.
initial begin
	repeat (8) @(posedge mclk);
	sys_rst <= 1'b0;
	ldup_host_model_inst.rd(7'h1A, rdv); `CHK(rdv, 13'h0000)
	ldup_host_model_inst.rd(7'h1B, rdv); `CHK(rdv, 13'h0000)
	for (int c = 0; c < 8; c++) begin
		ldup_host_model_inst.wr(7'h1A, 13'h1888 | 13'(c * 273));
		ldup_host_model_inst.wr(7'h1B, 13'h1888 | 13'(c * 273));
		ldup_host_model_inst.rd(7'h1A, rdv); `CHK(rdv, 13'(c * 273))
		ldup_host_model_inst.rd(7'h1B, rdv); `CHK(rdv, 13'(c * 273))
	end
	ldup_host_model_inst.wr(7'h19, 13'h0000);
	ldup_host_model_inst.rd(7'h1C, rdv); `CHK(rdv, 13'h0000)
	ldup_host_model_inst.rd(7'h1A, rdv); `CHK(rdv, 13'h0777)
	ldup_host_model_inst.wr(7'h1A, 13'h0210);
	ldup_host_model_inst.wr(7'h1B, 13'h0753);
	repeat (32768) @(posedge mclk);
	#1 on = 1;
	repeat (32768) @(posedge mclk);
	#1 on = 0;
	for (int i = 0; i < 6; i++) `CHK(cnt[i], expc(codes[i]))
	stop_test;
end
endmodule
